// ### csm_pkg.sv
package csm_pkg;
	// Sample and oscillator widths.
	localparam int CSM_DW = 16;
	localparam int CSM_FW = 32;
	localparam int CSM_PW = 16;
	// Register byte offsets.
	localparam logic [7:0] CSM_OFS_FREQ0 = 8'h00;
	localparam logic [7:0] CSM_OFS_FREQ1 = 8'h04;
	localparam logic [7:0] CSM_OFS_PHASE0 = 8'h08;
	localparam logic [7:0] CSM_OFS_PHASE1 = 8'h0c;
	localparam logic [7:0] CSM_OFS_GAIN = 8'h10;
	localparam logic [7:0] CSM_OFS_SYNC = 8'h14;
	localparam logic [7:0] CSM_OFS_STATUS = 8'h18;
	// Field positions in the gain configuration register.
	localparam int CSM_GAIN_BIT = 0;
	localparam int CSM_FMIX0_BIT = 1;
	localparam int CSM_CMIX0_LSB = 4;
	localparam int CSM_GAIN_W = 12;
	// Bit positions inside a four-bit coarse shift select.
	localparam int CSM_CMIX_FS8 = 3;
	localparam int CSM_CMIX_FS4 = 2;
	localparam int CSM_CMIX_FS2 = 1;
	localparam int CSM_CMIX_NFS4 = 0;
	// Field positions in the sync configuration and status registers.
	localparam int CSM_SYNC_SEL_LSB = 0;
	localparam int CSM_SYNC_SOFT_BIT = 8;
	localparam int CSM_STAT_ISO0_BIT = 4;
	// Values after reset.
	localparam logic [31:0] CSM_FREQ_RST = 32'h0000_0000;
	localparam logic [15:0] CSM_PHASE_RST = 16'h0000;
	localparam logic [11:0] CSM_GAIN_CFG_RST = 12'h000;
	localparam logic [3:0] CSM_SYNC_SEL_RST = 4'h0;
	// Angle bit that one fs/8 step sets in a 16-bit angle.
	localparam int CSM_FS8_SHIFT = 13;
	// Cycles from an input sample to its output sample.
	localparam int CSM_LATENCY = 3;

	// Negation that saturates the one value with no positive twin.
	function automatic logic signed [15:0] csm_neg_sat(input logic signed [15:0] x);
		return (x == 16'sh8000) ? 16'sh7fff : -x;
	endfunction : csm_neg_sat
endpackage : csm_pkg

// ### csm_nco.sv
`timescale 1ns/1ps
module csm_nco
	import csm_pkg::*;
#(
	parameter int FW = CSM_FW
)
(
	// Clock and reset.
	input logic pclk,
	input logic presetn,
	// Control.
	input logic sync_clear,
	input logic [FW-1:0] freq_word,
	input logic [15:0] phase_offset,
	input logic fixed_en,
	input logic [2:0] fixed_idx,
	// Registered sine and cosine terms.
	output logic signed [15:0] sin_reg,
	output logic signed [15:0] cos_reg
);
	logic [FW-1:0] acc_reg;
	logic [15:0] angle;

	// Quarter-wave table of a full-scale sine in 16 steps per quadrant.
	function automatic logic [15:0] qsin(input logic [4:0] k);
		case (k)
			5'h00: return 16'h0000;
			5'h01: return 16'h0c8c;
			5'h02: return 16'h18f9;
			5'h03: return 16'h2528;
			5'h04: return 16'h30fc;
			5'h05: return 16'h3c57;
			5'h06: return 16'h471d;
			5'h07: return 16'h5134;
			5'h08: return 16'h5a82;
			5'h09: return 16'h62f2;
			5'h0a: return 16'h6a6e;
			5'h0b: return 16'h70e3;
			5'h0c: return 16'h7642;
			5'h0d: return 16'h7a7d;
			5'h0e: return 16'h7d8a;
			5'h0f: return 16'h7f62;
			default: return 16'h7fff;
		endcase
	endfunction : qsin

	// Quadrant folding; the table is coarse, trading spur level for area.
	function automatic logic signed [15:0] sin_of(input logic [15:0] ang);
		logic [15:0] mag;
		mag = ang[14] ? qsin(5'h10 - {1'b0, ang[13:10]}) : qsin({1'b0, ang[13:10]});
		return ang[15] ? -signed'(mag) : signed'(mag);
	endfunction : sin_of

	// The accumulator wraps by plain overflow and restarts at zero on sync.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			acc_reg <= '0;
		else if (sync_clear)
			acc_reg <= '0;
		else
			acc_reg <= acc_reg + freq_word;
	end

	// Offset joins the top accumulator bits, or the fixed fs/8 angle is used.
	assign angle = fixed_en ? {fixed_idx, 13'h0000} : acc_reg[FW-1:FW-16] + phase_offset;

	// Sine and cosine leave one register after the angle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sin_reg <= '0;
			cos_reg <= '0;
		end
		else
		begin
			sin_reg <= sin_of(angle);
			cos_reg <= sin_of(angle + 16'h4000);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_accum_step;
		!sync_clear |=> acc_reg == FW'($past(acc_reg) + $past(freq_word));
	endproperty
	a_accum_step: assert property (p_accum_step) else $error("accumulator step wrong");
	property p_sync_zero;
		sync_clear |=> acc_reg == '0;
	endproperty
	a_sync_zero: assert property (p_sync_zero) else $error("accumulator not cleared");
	property p_offset_quarter;
		!fixed_en && !sync_clear && acc_reg == '0 && phase_offset == 16'h4000
			|=> sin_reg == 16'sh7fff && cos_reg == 16'sh0000;
	endproperty
	a_offset_quarter: assert property (p_offset_quarter) else $error("phase offset ignored");
endmodule : csm_nco

// ### csm_cmul.sv
`timescale 1ns/1ps
module csm_cmul
	import csm_pkg::*;
(
	// Clock and reset.
	input logic pclk,
	input logic presetn,
	// Sample and oscillator terms.
	input logic signed [15:0] i_in,
	input logic signed [15:0] q_in,
	input logic signed [15:0] sin_in,
	input logic signed [15:0] cos_in,
	// Control.
	input logic gain,
	input logic bypass,
	// Registered products.
	output logic signed [15:0] i_reg,
	output logic signed [15:0] q_reg
);
	logic signed [31:0] p_ic;
	logic signed [31:0] p_qs;
	logic signed [31:0] p_is;
	logic signed [31:0] p_qc;
	logic signed [32:0] sum_i;
	logic signed [32:0] sum_q;

	// Scale by one or one half, then clip; gain one can exceed full scale.
	function automatic logic signed [15:0] scale_sat(input logic signed [32:0] s, input logic g);
		logic signed [32:0] t;
		t = g ? (s >>> 15) : (s >>> 16);
		if (t > 33'sh0_0000_7fff)
			return 16'sh7fff;
		if (t < -33'sh0_0000_8000)
			return 16'sh8000;
		return t[15:0];
	endfunction : scale_sat

	// Complex product of the sample with the oscillator terms.
	assign p_ic = i_in * cos_in;
	assign p_qs = q_in * sin_in;
	assign p_is = i_in * sin_in;
	assign p_qc = q_in * cos_in;
	assign sum_i = 33'(p_ic) - 33'(p_qs);
	assign sum_q = 33'(p_is) + 33'(p_qc);

	// Bypassed samples skip the multiplier and its gain.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			i_reg <= '0;
			q_reg <= '0;
		end
		else if (bypass)
		begin
			i_reg <= i_in;
			q_reg <= q_in;
		end
		else
		begin
			i_reg <= scale_sat(sum_i, gain);
			q_reg <= scale_sat(sum_q, gain);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_bypass;
		bypass |=> i_reg == $past(i_in) && q_reg == $past(q_in);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered sample");
	property p_gain_levels;
		!bypass && sin_in == 16'sh0000 && cos_in == 16'sh7fff && i_in == 16'sh4000
			|=> i_reg == ($past(gain) ? 16'sh3fff : 16'sh1fff);
	endproperty
	a_gain_levels: assert property (p_gain_levels) else $error("mixer gain scale wrong");
endmodule : csm_cmul

// ### csm_mixer.sv
`timescale 1ns/1ps
module csm_mixer
	import csm_pkg::*;
#(
	parameter int FW = CSM_FW
)
(
	// Clock and reset.
	input logic pclk,
	input logic presetn,
	// APB slave.
	input logic [7:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Synchronisation sources, levels synchronous to pclk.
	input logic [3:0] sync_sources,
	// Samples from the interpolation datapath.
	input logic in_valid,
	input logic signed [15:0] in_i_pair0,
	input logic signed [15:0] in_q_pair0,
	input logic signed [15:0] in_i_pair1,
	input logic signed [15:0] in_q_pair1,
	// Samples toward the correction stage.
	output logic out_valid,
	output logic signed [15:0] out_i_pair0,
	output logic signed [15:0] out_q_pair0,
	output logic signed [15:0] out_i_pair1,
	output logic signed [15:0] out_q_pair1
);
	logic [FW-1:0] freq_word_reg [2];
	logic [15:0] phase_offset_reg [2];
	logic [CSM_GAIN_W-1:0] gain_config_reg;
	logic [3:0] sync_config_reg;
	logic soft_sync_reg;
	logic [3:0] sync_prev_reg;
	logic sync_event;
	logic [2:0] cnt_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_word;
	logic access;
	logic wr_fire;
	logic [1:0] iso;
	logic v0_reg;
	logic v1_reg;
	logic out_valid_reg;
	logic [1:0] idx0_reg;
	logic [1:0] idx1_reg;
	logic signed [15:0] in_i [2];
	logic signed [15:0] in_q [2];
	logic signed [15:0] out_i_reg [2];
	logic signed [15:0] out_q_reg [2];

	// Register map decoding; the status word is the only read-only one.
	function automatic logic is_writable(input logic [7:0] a);
		return a inside {CSM_OFS_FREQ0, CSM_OFS_FREQ1, CSM_OFS_PHASE0, CSM_OFS_PHASE1,
			CSM_OFS_GAIN, CSM_OFS_SYNC};
	endfunction : is_writable

	function automatic logic is_readable(input logic [7:0] a);
		return is_writable(a) || a == CSM_OFS_STATUS;
	endfunction : is_readable

	// Coarse negate-and-swap for sample index k of the four-sample cycle.
	function automatic logic [31:0] coarse_seq(input logic signed [15:0] i,
		input logic signed [15:0] q, input logic [1:0] k, input logic [3:0] cm);
		logic signed [15:0] ri;
		logic signed [15:0] rq;
		ri = i;
		rq = q;
		if (cm[CSM_CMIX_FS4])
		begin
			case (k)
				2'd1: begin ri = csm_neg_sat(q); rq = i; end
				2'd2: begin ri = csm_neg_sat(i); rq = csm_neg_sat(q); end
				2'd3: begin ri = q; rq = csm_neg_sat(i); end
				default: ;
			endcase
		end
		else if (cm[CSM_CMIX_NFS4])
		begin
			case (k)
				2'd1: begin ri = q; rq = csm_neg_sat(i); end
				2'd2: begin ri = csm_neg_sat(i); rq = csm_neg_sat(q); end
				2'd3: begin ri = csm_neg_sat(q); rq = i; end
				default: ;
			endcase
		end
		if (cm[CSM_CMIX_FS2] && k[0])
		begin
			ri = csm_neg_sat(ri);
			rq = csm_neg_sat(rq);
		end
		return {ri, rq};
	endfunction : coarse_seq

	// Ports of the two pairs gathered into indexable arrays.
	assign in_i[0] = in_i_pair0;
	assign in_q[0] = in_q_pair0;
	assign in_i[1] = in_i_pair1;
	assign in_q[1] = in_q_pair1;
	assign out_i_pair0 = out_i_reg[0];
	assign out_q_pair0 = out_q_reg[0];
	assign out_i_pair1 = out_i_reg[1];
	assign out_q_pair1 = out_q_reg[1];
	assign out_valid = out_valid_reg;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// Every access waits one cycle so the answer comes from flops.
	assign access = psel & penable;
	assign wr_fire = access & pready_reg & pwrite & is_writable(paddr);

	// Read multiplexer, with the pair isolation flags and sample index.
	always_comb
	begin
		rd_word = '0;
		case (paddr)
			CSM_OFS_FREQ0: rd_word = freq_word_reg[0];
			CSM_OFS_FREQ1: rd_word = freq_word_reg[1];
			CSM_OFS_PHASE0: rd_word = {16'h0000, phase_offset_reg[0]};
			CSM_OFS_PHASE1: rd_word = {16'h0000, phase_offset_reg[1]};
			CSM_OFS_GAIN: rd_word = {20'h00000, gain_config_reg};
			CSM_OFS_SYNC: rd_word = {28'h0000000, sync_config_reg};
			CSM_OFS_STATUS: rd_word = {26'h0000000, iso, 1'b0, cnt_reg};
			default: rd_word = '0;
		endcase
	end

	// Answer phase: pready rises one cycle into the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end
		else if (access && !pready_reg)
		begin
			pready_reg <= 1'b1;
			prdata_reg <= (!pwrite && is_readable(paddr)) ? rd_word : '0;
			pslverr_reg <= pwrite ? !is_writable(paddr) : !is_readable(paddr);
		end
		else
		begin
			pready_reg <= 1'b0;
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end
	end

	// Configuration registers take effect at the completing edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			freq_word_reg[0] <= CSM_FREQ_RST;
			freq_word_reg[1] <= CSM_FREQ_RST;
			phase_offset_reg[0] <= CSM_PHASE_RST;
			phase_offset_reg[1] <= CSM_PHASE_RST;
			gain_config_reg <= CSM_GAIN_CFG_RST;
			sync_config_reg <= CSM_SYNC_SEL_RST;
		end
		else if (wr_fire)
		begin
			case (paddr)
				CSM_OFS_FREQ0: freq_word_reg[0] <= pwdata;
				CSM_OFS_FREQ1: freq_word_reg[1] <= pwdata;
				CSM_OFS_PHASE0: phase_offset_reg[0] <= pwdata[15:0];
				CSM_OFS_PHASE1: phase_offset_reg[1] <= pwdata[15:0];
				CSM_OFS_GAIN: gain_config_reg <= pwdata[CSM_GAIN_W-1:0];
				CSM_OFS_SYNC: sync_config_reg <= pwdata[CSM_SYNC_SEL_LSB +: 4];
				default: ;
			endcase
		end
	end

	// Software sync strobe, a pulse that never reads back.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			soft_sync_reg <= 1'b0;
		else
			soft_sync_reg <= wr_fire && paddr == CSM_OFS_SYNC && pwdata[CSM_SYNC_SOFT_BIT];
	end

	// A rising edge on any enabled source is a sync event.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_prev_reg <= '0;
		else
			sync_prev_reg <= sync_sources;
	end
	assign sync_event = soft_sync_reg | (|(sync_sources & ~sync_prev_reg & sync_config_reg));

	// Sample index since the last sync, shared by coarse and fs/8 mixing.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= '0;
		else if (sync_event)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 3'd1;
	end

	// Valid flag and sample index travel alongside the data.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
			out_valid_reg <= 1'b0;
			idx0_reg <= '0;
			idx1_reg <= '0;
		end
		else
		begin
			v0_reg <= in_valid;
			v1_reg <= v0_reg;
			out_valid_reg <= v1_reg;
			idx0_reg <= cnt_reg[1:0];
			idx1_reg <= idx0_reg;
		end
	end

	// One full mixer, one multiplier and one coarse stage per channel pair.
	for (genvar p = 0; p < 2; p++)
	begin : g_path
		logic [3:0] cmix;
		logic full_complex_mixer_en;
		logic signed [15:0] sin_w;
		logic signed [15:0] cos_w;
		logic signed [15:0] d0_i_reg;
		logic signed [15:0] d0_q_reg;
		logic signed [15:0] m_i;
		logic signed [15:0] m_q;
		logic [31:0] seq_w;

		assign cmix = gain_config_reg[CSM_CMIX0_LSB + 4 * p +: 4];
		assign full_complex_mixer_en = gain_config_reg[CSM_FMIX0_BIT + p];
		// Only the unmixed and fs/2 modes keep I and Q apart.
		assign iso[p] = !full_complex_mixer_en && (cmix == 4'h0 || cmix == 4'h2);

		csm_nco #(.FW(FW)) u_nco (
			.pclk(pclk),
			.presetn(presetn),
			.sync_clear(sync_event),
			.freq_word(freq_word_reg[p]),
			.phase_offset(phase_offset_reg[p]),
			.fixed_en(!full_complex_mixer_en && cmix[CSM_CMIX_FS8]),
			.fixed_idx(cnt_reg),
			.sin_reg(sin_w),
			.cos_reg(cos_w)
		);

		// Data waits one cycle to meet its oscillator terms.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				d0_i_reg <= '0;
				d0_q_reg <= '0;
			end
			else
			begin
				d0_i_reg <= in_i[p];
				d0_q_reg <= in_q[p];
			end
		end

		csm_cmul u_cmul (
			.pclk(pclk),
			.presetn(presetn),
			.i_in(d0_i_reg),
			.q_in(d0_q_reg),
			.sin_in(sin_w),
			.cos_in(cos_w),
			.gain(gain_config_reg[CSM_GAIN_BIT]),
			.bypass(!(full_complex_mixer_en || cmix[CSM_CMIX_FS8])),
			.i_reg(m_i),
			.q_reg(m_q)
		);

		// Coarse sequences follow the multiplier, so fs/8 combines with them.
		assign seq_w = coarse_seq(m_i, m_q, idx1_reg, cmix);
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				out_i_reg[p] <= '0;
				out_q_reg[p] <= '0;
			end
			else
			begin
				out_i_reg[p] <= seq_w[31:16];
				out_q_reg[p] <= seq_w[15:0];
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_sync_index;
		sync_event |=> cnt_reg == 3'd0 ##1 cnt_reg == 3'd1;
	endproperty
	a_sync_index: assert property (p_sync_index) else $error("index not restarted");
	property p_sync_source;
		!soft_sync_reg |-> sync_event == (|(sync_sources & ~$past(sync_sources) & sync_config_reg));
	endproperty
	a_sync_source: assert property (p_sync_source) else $error("sync source wrong");
	property p_latency;
		out_valid == $past(in_valid, 3);
	endproperty
	a_latency: assert property (p_latency) else $error("valid latency wrong");
	property p_normal;
		gain_config_reg == $past(gain_config_reg, 3) && gain_config_reg[7:0] == 8'h00
			|-> out_i_pair0 == $past(in_i_pair0, 3) && out_q_pair0 == $past(in_q_pair0, 3);
	endproperty
	a_normal: assert property (p_normal) else $error("normal mode altered data");
	property p_fs2_odd;
		gain_config_reg == $past(gain_config_reg, 3) && gain_config_reg[7:0] == 8'h20
			&& $past(cnt_reg[0], 3) |-> out_i_pair0 == csm_neg_sat($past(in_i_pair0, 3))
			&& out_q_pair0 == csm_neg_sat($past(in_q_pair0, 3));
	endproperty
	a_fs2_odd: assert property (p_fs2_odd) else $error("fs/2 sign wrong");
	property p_fs4_second;
		gain_config_reg == $past(gain_config_reg, 3) && gain_config_reg[7:0] == 8'h40
			&& $past(cnt_reg[1:0], 3) == 2'd1 |-> out_i_pair0 == csm_neg_sat($past(in_q_pair0, 3))
			&& out_q_pair0 == $past(in_i_pair0, 3);
	endproperty
	a_fs4_second: assert property (p_fs4_second) else $error("+fs/4 swap wrong");
	property p_nfs4_fourth;
		gain_config_reg == $past(gain_config_reg, 3) && gain_config_reg[7:0] == 8'h10
			&& $past(cnt_reg[1:0], 3) == 2'd3 |-> out_i_pair0 == csm_neg_sat($past(in_q_pair0, 3))
			&& out_q_pair0 == $past(in_i_pair0, 3);
	endproperty
	a_nfs4_fourth: assert property (p_nfs4_fourth) else $error("-fs/4 swap wrong");
	property p_isolation;
		iso[0] == (gain_config_reg[7:0] == 8'h00 || gain_config_reg[7:0] == 8'h20);
	endproperty
	a_isolation: assert property (p_isolation) else $error("isolation flag wrong");
	property p_apb_answer;
		access && !pready_reg |=> pready_reg ##1 !pready_reg;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");
	c_sync: cover property (sync_event ##1 out_valid);
	c_fs4: cover property (gain_config_reg[7:4] == 4'h4 && out_valid);
	c_fs8_combo: cover property (gain_config_reg[7:4] == 4'he && out_valid);
	c_full_complex_mixer: cover property (gain_config_reg[CSM_FMIX0_BIT] && out_valid);
endmodule : csm_mixer

// ### csm_src_model.sv
`timescale 1ns/1ps
// Stand-in for the interpolation datapath: one sample per clock on every lane.
module csm_src_model
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Sample stream.
	output logic in_valid,
	output logic signed [15:0] in_i_pair0,
	output logic signed [15:0] in_q_pair0,
	output logic signed [15:0] in_i_pair1,
	output logic signed [15:0] in_q_pair1
);
	logic [13:0] seq_reg;

	// Lanes use different strides, so a swapped or negated lane never matches by chance.
	function automatic logic signed [15:0] lane(input logic [13:0] m);
		logic [13:0] p;
		p = seq_reg * m;
		return {{2{p[13]}}, p};
	endfunction : lane

	// Values stay within 14 bits, so a quarter-turn rotation can never clip.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seq_reg <= 14'h0000;
		else
			seq_reg <= seq_reg + 14'h0001;
	end

	// Valid has gaps; the data keeps changing through them.
	assign in_valid = seq_reg[1] | seq_reg[3];
	assign in_i_pair0 = lane(14'h0135);
	assign in_q_pair0 = lane(14'h0a53);
	assign in_i_pair1 = lane(14'h1c07);
	assign in_q_pair1 = lane(14'h2319);
endmodule : csm_src_model

// ### csm_mixer_tb.sv
`timescale 1ns/1ps
module csm_mixer_tb
	import csm_pkg::*;
;
	typedef struct packed {logic v; logic [1:0] c; logic [1:0] t; logic [63:0] s;} csm_exp_t;
	localparam logic [3:0] CODES [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'ha, 4'hc, 4'he};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, out_valid;
	logic chk_on, gain, sy_prev;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] sync_sources, cm;
	logic signed [15:0] in_i_pair0, in_q_pair0, in_i_pair1, in_q_pair1;
	logic signed [15:0] out_i_pair0, out_q_pair0, out_i_pair1, out_q_pair1;
	logic [2:0] k8, e8;
	logic [2:0] b8 [2];
	logic [2:0] s8 [2];
	logic mul [2];
	logic [63:0] ins, got;
	csm_exp_t d [3];
	csm_exp_t nw;
	int n_mismatch, n_compared;

	csm_mixer uut
	(
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .sync_sources, .in_valid, .in_i_pair0, .in_q_pair0, .in_i_pair1,
		.in_q_pair1, .out_valid, .out_i_pair0, .out_q_pair0, .out_i_pair1, .out_q_pair1
	);

	csm_src_model src
	(
		.pclk, .presetn, .in_valid, .in_i_pair0, .in_q_pair0, .in_i_pair1, .in_q_pair1
	);

	// Free-running 40 MHz clock.
	always #12.5 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_reg

	// Multiplier results round, so they get a small tolerance; pure swaps must be exact.
	task automatic chk_smp(input logic signed [15:0] g, input logic signed [15:0] e,
		input logic t);
		logic signed [16:0] df;
		n_compared++;
		df = g - e;
		if ((t ? (df >= -2 && df <= 2) : (df == 0)) !== 1'b1)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_smp

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rv, output logic ev);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : apb

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] wd, input logic ee);
		logic [31:0] rv;
		logic ev;
		apb(a, 1'b1, wd, rv, ev);
		chk_reg({31'h0, ev}, {31'h0, ee});
	endtask : wr_chk

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee,
		input logic [31:0] mask);
		logic [31:0] rv;
		logic ev;
		apb(a, 1'b0, 32'h0, rv, ev);
		chk_reg(rv & mask, e);
		chk_reg({31'h0, ev}, {31'h0, ee});
	endtask : rd_chk

	function automatic logic signed [15:0] ng(input logic signed [15:0] x);
		return (x == 16'sh8000) ? 16'sh7fff : -x;
	endfunction : ng

	// Rotation by r quarter turns, halved when the multiplier runs at the lower gain.
	function automatic logic [31:0] rot(input logic signed [15:0] i,
		input logic signed [15:0] q, input logic [1:0] r, input logic half);
		logic signed [15:0] a;
		logic signed [15:0] b;
		case (r)
			2'd0: {a, b} = {i, q};
			2'd1: {a, b} = {ng(q), i};
			2'd2: {a, b} = {ng(i), ng(q)};
			default: {a, b} = {q, ng(i)};
		endcase
		return half ? {a >>> 1, b >>> 1} : {a, b};
	endfunction : rot

	// Each select bit adds its own rotation in eighths of a turn per sample.
	function automatic logic [2:0] step8(input logic [3:0] c);
		return {2'b0, c[3]} + (c[2] ? 3'd2 : 3'd0) + {c[1], 2'b0} + (c[0] ? 3'd6 : 3'd0);
	endfunction : step8

	// Expected samples go through a three-stage queue to meet the fixed latency.
	always @(posedge pclk)
	begin
		got = {out_i_pair0, out_q_pair0, out_i_pair1, out_q_pair1};
		if (chk_on)
		begin
			for (int j = 0; j < 4; j++)
				if (d[2].c[j/2])
					chk_smp(got[63-16*j -: 16], d[2].s[63-16*j -: 16], d[2].t[j/2]);
			chk_reg({31'h0, out_valid}, {31'h0, d[2].v});
		end
		ins = {in_i_pair0, in_q_pair0, in_i_pair1, in_q_pair1};
		nw.v = in_valid;
		for (int p = 0; p < 2; p++)
		begin
			e8 = b8[p] + s8[p] * k8;
			nw.c[p] = ~e8[0];
			nw.t[p] = mul[p];
			nw.s[63-32*p -: 32] = rot(ins[63-32*p -: 16], ins[47-32*p -: 16], e8[2:1],
				mul[p] & ~gain);
		end
		d[2] = d[1];
		d[1] = d[0];
		d[0] = nw;
		k8 = (sync_sources[0] && !sy_prev) ? 3'h0 : k8 + 3'h1;
		sy_prev = sync_sources[0];
	end

	// An unselected source pulses mid-window; it must not restart the sequence.
	task automatic run_mode(input logic [1:0] iso);
		@(posedge pclk);
		sync_sources <= 4'h1;
		@(posedge pclk);
		sync_sources <= 4'h0;
		repeat (6) @(posedge pclk);
		chk_on <= 1'b1;
		repeat (12) @(posedge pclk);
		sync_sources <= 4'h4;
		@(posedge pclk);
		sync_sources <= 4'h0;
		repeat (12) @(posedge pclk);
		chk_on <= 1'b0;
		rd_chk(CSM_OFS_STATUS, {26'h0, iso, 4'h0}, 1'b0, 32'h30);
	endtask : run_mode

	// Hang guard.
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, chk_on, gain, sy_prev} = 8'h00;
		{paddr, pwdata, sync_sources, k8} = '0;
		{n_mismatch, n_compared} = '0;
		b8 = '{3'h0, 3'h0};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(CSM_OFS_GAIN, 32'h0, 1'b0, '1);
		rd_chk(CSM_OFS_FREQ0, 32'h0, 1'b0, '1);
		wr_chk(CSM_OFS_FREQ1, 32'h9abc_1235, 1'b0);
		rd_chk(CSM_OFS_FREQ1, 32'h9abc_1235, 1'b0, '1);
		wr_chk(CSM_OFS_PHASE0, 32'hffff_ffff, 1'b0);
		rd_chk(CSM_OFS_PHASE0, 32'h0000_ffff, 1'b0, '1);
		wr_chk(8'h1c, 32'h1, 1'b1);
		rd_chk(8'h1c, 32'h0, 1'b1, '1);
		wr_chk(CSM_OFS_STATUS, 32'h1, 1'b1);
		wr_chk(CSM_OFS_SYNC, 32'h1, 1'b0);
		rd_chk(CSM_OFS_SYNC, 32'h1, 1'b0, '1);
		// Every listed code on each pair, both gains; no unlisted code is programmed.
		for (int m = 0; m < 8; m++)
		begin
			gain = m[0];
			for (int p = 0; p < 2; p++)
			begin
				cm = p ? CODES[7-m] : CODES[m];
				s8[p] = step8(cm);
				mul[p] = cm[3];
			end
			wr_chk(CSM_OFS_GAIN, {20'h0, CODES[7-m], CODES[m], 3'h0, gain}, 1'b0);
			cm = CODES[7-m];
			run_mode({cm == 4'h0 || cm == 4'h2, CODES[m] == 4'h0 || CODES[m] == 4'h2});
		end
		// Quarter-turn oscillator on pair0, fixed quarter-turn offset on pair1.
		wr_chk(CSM_OFS_FREQ0, 32'h4000_0000, 1'b0);
		wr_chk(CSM_OFS_PHASE0, 32'h0, 1'b0);
		wr_chk(CSM_OFS_FREQ1, 32'h0, 1'b0);
		wr_chk(CSM_OFS_PHASE1, 32'h0000_4000, 1'b0);
		wr_chk(CSM_OFS_GAIN, 32'h0000_0007, 1'b0);
		b8 = '{3'h0, 3'h2};
		s8 = '{3'h2, 3'h0};
		mul = '{1'b1, 1'b1};
		gain = 1'b1;
		run_mode(2'b00);
		tally_and_finish();
	end
endmodule : csm_mixer_tb
